// File: shared/fhp_pkg.sv
package fhp_pkg;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 16;
  localparam int CLK_MHZ = 25;
  // Bus phase times in ns
  localparam int T_SETUP_NS = 80;
  localparam int T_STROBE_NS = 120;
  localparam int T_HOLD_NS = 40;
  localparam int T_RESET_NS = 200;
  localparam int SETUP_CYC = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int STROBE_CYC = (T_STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int HOLD_CYC = (T_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int RESET_CYC = (T_RESET_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 8;
  localparam int MAX_HIGH_V_CYCLES = 100;
  localparam int HV_CNT_W = 7;
  localparam logic [1:0] RP_LOW = 2'h0;
  localparam logic [1:0] RP_HIGH = 2'h1;
  localparam logic [1:0] RP_UNLOCK = 2'h2;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_CONFIRM = 8'hd0;
  localparam logic [7:0] CMD_WRITE_SETUP = 8'h40;
  localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
  typedef enum logic [2:0] {
    FHP_IDLE = 3'b000,
    FHP_SETUP = 3'b001,
    FHP_STROBE = 3'b010,
    FHP_HOLD = 3'b011,
    FHP_RESET = 3'b100
  } fhp_state_t;
endpackage

// File: src/fhp_timer.sv
`timescale 1ns/1ps
module fhp_timer
  import fhp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [CNT_W-1:0] value,
  output logic done
);
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic next_done;

  always_comb
  begin
    next_count = count;
    next_done = 1'b0;
    if (load)
    begin
      next_count = value;
    end
    else if (count != '0)
    begin
      next_count = count - 1'b1;
      next_done = (count == 8'h01);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      count <= '0;
      done <= 1'b0;
    end
    else
    begin
      count <= next_count;
      done <= next_done;
    end
  end
endmodule

// File: src/fhp_host.sv
`timescale 1ns/1ps
// Behaviour
// - Reset held low during a requested reset, at the unlock level during unlocked confirm writes, normal high otherwise
// - Low byte carries data and commands
// - Program supply valid confirm to done
// - High supply limited to 100 cycles
module fhp_host
  import fhp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_byte,
  input wire logic req_boot_unlock,
  input wire logic req_confirm,
  input wire logic req_high_supply,
  input wire logic [fhp_pkg::ADDR_W-1:0] req_addr,
  input wire logic [fhp_pkg::DATA_W-1:0] req_wdata,
  input wire logic req_reset,
  input wire logic op_done,
  output logic req_ready,
  output logic rsp_valid,
  output logic [fhp_pkg::DATA_W-1:0] rsp_rdata,
  output logic [1:0] reset_powerdown_level,
  output logic chip_select_n,
  output logic output_enable_n,
  output logic write_strobe_n,
  output logic write_guard,
  output logic width_word,
  output logic program_supply_on,
  output logic program_supply_high,
  output logic [fhp_pkg::ADDR_W-1:0] address_lines,
  input wire logic [fhp_pkg::DATA_W-1:0] data_in,
  output logic [fhp_pkg::DATA_W-1:0] data_out,
  output logic [fhp_pkg::DATA_W-1:0] data_oe
);
  import fhp_pkg::*;

  fhp_state_t state, next_state;
  logic is_write, next_is_write;
  logic is_byte, next_is_byte;
  logic next_req_ready, next_rsp_valid;
  logic [DATA_W-1:0] next_rsp_rdata, next_data_out, next_data_oe;
  logic [1:0] next_rp;
  logic next_cs_n, next_oe_n, next_we_n, next_wg, next_ww, next_vpp, next_vpph;
  logic [ADDR_W-1:0] next_addr;
  logic [HV_CNT_W-1:0] hv_uses, next_hv_uses;
  logic t_load, t_done;
  logic [CNT_W-1:0] t_value;

  fhp_timer u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .load(t_load),
    .value(t_value),
    .done(t_done)
  );

  function automatic logic [DATA_W-1:0] lane_enable(input logic byte_mode);
    lane_enable = byte_mode ? 16'h00ff : 16'hffff;
  endfunction

  always_comb
  begin
    next_state = state;
    next_is_write = is_write;
    next_is_byte = is_byte;
    next_req_ready = req_ready;
    next_rsp_valid = 1'b0;
    next_rsp_rdata = rsp_rdata;
    next_rp = reset_powerdown_level;
    next_cs_n = chip_select_n;
    next_oe_n = output_enable_n;
    next_we_n = write_strobe_n;
    next_wg = write_guard;
    next_ww = width_word;
    next_vpp = program_supply_on;
    next_vpph = program_supply_high;
    next_addr = address_lines;
    next_data_out = data_out;
    next_data_oe = data_oe;
    next_hv_uses = hv_uses;
    t_load = 1'b0;
    t_value = '0;
    if (program_supply_on && op_done)
    begin
      next_vpp = 1'b0;
      next_vpph = 1'b0;
    end
    case (state)
      FHP_IDLE:
      begin
        if (req_reset)
        begin
          next_rp = RP_LOW;
          next_cs_n = 1'b1;
          next_oe_n = 1'b1;
          next_data_oe = '0;
          next_req_ready = 1'b0;
          t_load = 1'b1;
          t_value = CNT_W'(RESET_CYC);
          next_state = FHP_RESET;
        end
        else if (req_valid)
        begin
          next_req_ready = 1'b0;
          next_is_write = req_write;
          next_is_byte = req_byte;
          next_ww = !req_byte;
          next_addr = req_addr;
          next_wg = req_write && req_boot_unlock;
          next_rp = (req_write && req_boot_unlock && req_confirm) ? RP_UNLOCK : RP_HIGH;
          if (req_write && req_confirm)
          begin
            next_vpp = 1'b1;
            next_vpph = req_high_supply && (hv_uses < HV_CNT_W'(MAX_HIGH_V_CYCLES));
            if (next_vpph)
            begin
              next_hv_uses = hv_uses + 1'b1;
            end
          end
          next_cs_n = 1'b0;
          if (req_write)
          begin
            next_data_out = req_wdata;
            next_data_oe = lane_enable(req_byte);
          end
          else
          begin
            next_data_oe = '0;
          end
          if (req_byte)
          begin
            next_data_out[DATA_W-1] = req_addr[0];
            next_data_oe[DATA_W-1] = 1'b1;
            next_addr = {1'b0, req_addr[ADDR_W-1:1]};
          end
          t_load = 1'b1;
          t_value = CNT_W'(SETUP_CYC);
          next_state = FHP_SETUP;
        end
      end
      FHP_SETUP:
      begin
        if (t_done)
        begin
          if (is_write)
          begin
            next_we_n = 1'b0;
          end
          else
          begin
            next_oe_n = 1'b0;
          end
          t_load = 1'b1;
          t_value = CNT_W'(STROBE_CYC);
          next_state = FHP_STROBE;
        end
      end
      FHP_STROBE:
      begin
        if (t_done)
        begin
          if (!is_write)
          begin
            next_rsp_rdata = is_byte ? {8'h00, data_in[7:0]} : data_in;
            next_rsp_valid = 1'b1;
          end
          next_we_n = 1'b1;
          next_oe_n = 1'b1;
          t_load = 1'b1;
          t_value = CNT_W'(HOLD_CYC);
          next_state = FHP_HOLD;
        end
      end
      FHP_HOLD:
      begin
        if (t_done)
        begin
          next_cs_n = 1'b1;
          next_data_oe = '0;
          next_wg = 1'b0;
          next_rp = RP_HIGH;
          next_req_ready = 1'b1;
          next_state = FHP_IDLE;
        end
      end
      FHP_RESET:
      begin
        if (t_done)
        begin
          next_rp = RP_HIGH;
          next_req_ready = 1'b1;
          next_state = FHP_IDLE;
        end
      end
      default:
      begin
        next_state = FHP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state <= FHP_IDLE;
      is_write <= 1'b0;
      is_byte <= 1'b0;
      req_ready <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
      reset_powerdown_level <= RP_HIGH;
      chip_select_n <= 1'b1;
      output_enable_n <= 1'b1;
      write_strobe_n <= 1'b1;
      write_guard <= 1'b0;
      width_word <= 1'b1;
      program_supply_on <= 1'b0;
      program_supply_high <= 1'b0;
      address_lines <= '0;
      data_out <= '0;
      data_oe <= '0;
      hv_uses <= '0;
    end
    else
    begin
      state <= next_state;
      is_write <= next_is_write;
      is_byte <= next_is_byte;
      req_ready <= next_req_ready;
      rsp_valid <= next_rsp_valid;
      rsp_rdata <= next_rsp_rdata;
      reset_powerdown_level <= next_rp;
      chip_select_n <= next_cs_n;
      output_enable_n <= next_oe_n;
      write_strobe_n <= next_we_n;
      write_guard <= next_wg;
      width_word <= next_ww;
      program_supply_on <= next_vpp;
      program_supply_high <= next_vpph;
      address_lines <= next_addr;
      data_out <= next_data_out;
      data_oe <= next_data_oe;
      hv_uses <= next_hv_uses;
    end
  end

  sequence s_strobe_low;
    !output_enable_n;
  endsequence

  a_reset_floats: assert property (@(posedge clk) disable iff (!rst_n)
    (reset_powerdown_level == RP_LOW) |-> (data_oe == '0))
    else $error("Data driven during reset");
  a_reset_deselect: assert property (@(posedge clk) disable iff (!rst_n)
    (reset_powerdown_level == RP_LOW) |-> chip_select_n)
    else $error("Chip selected during reset");
  a_read_no_drive: assert property (@(posedge clk) disable iff (!rst_n)
    s_strobe_low |-> (data_oe[7:0] == 8'h00))
    else $error("Host drives low byte while device outputs");
  a_no_overlap: assert property (@(posedge clk) disable iff (!rst_n)
    !(!output_enable_n && !write_strobe_n))
    else $error("Read and write strobes overlap");
  a_unlock_only_write: assert property (@(posedge clk) disable iff (!rst_n)
    (reset_powerdown_level == RP_UNLOCK) |-> !chip_select_n && is_write)
    else $error("Unlock level outside a write");
  a_level_legal: assert property (@(posedge clk) disable iff (!rst_n)
    reset_powerdown_level != 2'h3)
    else $error("Illegal reset level");
  a_byte_middle_float: assert property (@(posedge clk) disable iff (!rst_n)
    (!width_word && !chip_select_n) |-> (data_oe[14:8] == 7'h00))
    else $error("Middle pins driven in byte width");
  a_high_supply_count: assert property (@(posedge clk) disable iff (!rst_n)
    hv_uses <= HV_CNT_W'(MAX_HIGH_V_CYCLES))
    else $error("High supply overused");
  a_strobe_after_select: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(write_strobe_n) |-> !$past(chip_select_n, 2))
    else $error("Write strobe without setup");
endmodule

// File: sim/fhp_flash_model.sv
`timescale 1ns/1ps
module fhp_flash_model
  import fhp_pkg::*;
(
  input wire logic clk,
  input wire logic [1:0] rp,
  input wire logic cs_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic wg,
  input wire logic ww,
  input wire logic vpp,
  input wire logic [16:0] a,
  input wire logic [15:0] d,
  output logic [15:0] q,
  output logic op_done
);
  logic [15:0] mem [16];
  logic [15:0] last;
  logic [15:0] rd;
  logic [15:0] en;
  logic [7:0] status;
  logic armed;
  logic stat;
  logic we_q;
  logic [3:0] busy;
  wire act = rp != RP_LOW && !cs_n;
  wire [3:0] w = a[3:0];
  wire ok = vpp && (w > 4'h3 || wg || rp == RP_UNLOCK);
  // Released pins show a changing pattern, not a held value
  assign rd = stat ? {8'h00, status} : ww ? mem[w] : {8'h00, d[15] ? mem[w][15:8] : mem[w][7:0]};
  assign en = !(act && !oe_n && we_n) ? 16'h0000 : ww ? 16'hffff : 16'h00ff;
  assign q = (en & rd) | (~en & ~last);
  initial
  begin
    for (int i = 0; i < 16; i++)
      mem[i] = 16'h1100 + i[15:0];
    last = 16'h0000;
    busy = 4'h0;
    stat = 1'b0;
    armed = 1'b0;
  end
  always @(posedge clk)
  begin
    last <= q;
    we_q <= we_n;
    op_done <= busy == 4'h1;
    if (busy != 4'h0)
      busy <= busy - 4'h1;
    if (busy == 4'h1)
      status <= 8'h80;
    if (rp == RP_LOW)
    begin
      status <= 8'h00;
      stat <= 1'b0;
      armed <= 1'b0;
      busy <= 4'h0;
    end
    else if (act && !we_q && we_n)
    begin
      armed <= d[7:0] == CMD_WRITE_SETUP && !armed;
      stat <= armed || d[7:0] != CMD_READ_ARRAY;
      if (armed)
        busy <= 4'h3;
      if (armed && ok && ww)
        mem[w] <= d;
      else if (armed && ok && d[15])
        mem[w][15:8] <= d[7:0];
      else if (armed && ok)
        mem[w][7:0] <= d[7:0];
    end
  end
endmodule

// File: sim/fhp_host_test.sv
`timescale 1ns/1ps
module fhp_host_test;
  import fhp_pkg::*;
  logic clk = 0, rst_n = 0, req_valid = 0, req_write = 0, req_byte = 0, req_boot_unlock = 0;
  logic req_confirm = 0, req_reset = 0, op_done, req_ready, rsp_valid, chip_select_n;
  logic output_enable_n, write_strobe_n, write_guard, width_word, program_supply_on;
  logic program_supply_high, req_high_supply = 0, saw_unlock = 0, saw_low = 0;
  logic [1:0] reset_powerdown_level;
  logic [16:0] req_addr = 0, address_lines;
  logic [15:0] req_wdata = 0, rsp_rdata, data_in, data_out, data_oe, dev_q, got;
  int error_cnt = 0, comparisons = 0;
  always #20 clk = ~clk;
  assign data_in = (data_oe & data_out) | (~data_oe & dev_q);
  fhp_host u_dut (.*);
  fhp_flash_model u_mem (.clk(clk), .rp(reset_powerdown_level), .cs_n(chip_select_n),
    .oe_n(output_enable_n), .we_n(write_strobe_n), .wg(write_guard), .ww(width_word),
    .vpp(program_supply_on), .a(address_lines), .d(data_in), .q(dev_q), .op_done(op_done));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    @(negedge clk);
    while (req_ready !== 1'b1)
    begin
      n++;
      if (n > 100)
      begin
        error_cnt++;
        final_report();
      end
      @(negedge clk);
    end
    @(posedge clk);
  endtask
  task automatic access(input logic wr, byt, unl, conf, input logic [16:0] a,
    input logic [15:0] d);
    int n;
    wait_ready();
    req_valid <= 1'b1;
    req_write <= wr;
    req_byte <= byt;
    req_boot_unlock <= unl;
    req_confirm <= conf;
    req_addr <= a;
    req_wdata <= d;
    @(posedge clk);
    req_valid <= 1'b0;
    n = 0;
    while (!wr && rsp_valid !== 1'b1 && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    got = rsp_rdata;
    if (n == 20)
    begin
      error_cnt++;
      final_report();
    end
  endtask
  task automatic wr2(input logic byt, unl, input logic [16:0] a, input logic [15:0] d);
    access(1'b1, byt, 1'b0, 1'b0, a, 16'h0040);
    access(1'b1, byt, unl, 1'b1, a, d);
  endtask
  task automatic rd(input logic byt, input logic [16:0] a);
    access(1'b1, 1'b0, 1'b0, 1'b0, 17'h0_0000, 16'h00ff);
    access(1'b0, byt, 1'b0, 1'b0, a, 16'h0000);
  endtask
  always @(negedge clk)
  begin
    // Pin 15 carries the byte address in byte width, even while reading
    if (rst_n && (data_oe & {width_word, 15'h7fff}) !== 16'h0000)
      check("oe_n while driving", {15'h0000, output_enable_n}, 16'h0001);
    if (reset_powerdown_level === RP_LOW)
      check("float in reset", data_oe, 16'h0000);
    if (op_done === 1'b1)
      check("supply at done", {15'h0000, program_supply_on}, 16'h0001);
    if (reset_powerdown_level === RP_UNLOCK)
      saw_unlock <= 1'b1;
    if (reset_powerdown_level === RP_LOW)
      saw_low <= 1'b1;
  end
  task automatic sc_word();
    wr2(1'b0, 1'b0, 17'h0_0005, 16'ha5c3);
    rd(1'b0, 17'h0_0005);
    check("word read", got, 16'ha5c3);
    rd(1'b0, 17'h0_0007);
    check("word untouched", got, 16'h1107);
  endtask
  task automatic sc_byte();
    rd(1'b1, 17'h0_000b);
    check("byte high", {8'h00, got[7:0]}, 16'h00a5);
    rd(1'b1, 17'h0_000a);
    check("byte low", {8'h00, got[7:0]}, 16'h00c3);
    wr2(1'b1, 1'b0, 17'h0_000d, 16'h005a);
    rd(1'b0, 17'h0_0006);
    check("byte write", got, 16'h5a06);
  endtask
  task automatic sc_boot();
    wr2(1'b0, 1'b0, 17'h0_0001, 16'hbeef);
    rd(1'b0, 17'h0_0001);
    check("boot locked", got, 16'h1101);
    wr2(1'b0, 1'b1, 17'h0_0001, 16'hbeef);
    rd(1'b0, 17'h0_0001);
    check("boot unlocked", got, 16'hbeef);
    check("unlock level", {15'h0000, saw_unlock}, 16'h0001);
  endtask
  task automatic sc_reset();
    access(1'b1, 1'b0, 1'b0, 1'b0, 17'h0_0000, 16'h0040);
    access(1'b0, 1'b0, 1'b0, 1'b0, 17'h0_0005, 16'h0000);
    check("status before reset", got, 16'h0080);
    wait_ready();
    req_reset <= 1'b1;
    @(posedge clk);
    req_reset <= 1'b0;
    access(1'b0, 1'b0, 1'b0, 1'b0, 17'h0_0005, 16'h0000);
    check("low level seen", {15'h0000, saw_low}, 16'h0001);
    check("array after reset", got, 16'ha5c3);
    access(1'b1, 1'b0, 1'b0, 1'b0, 17'h0_0000, 16'h0020);
    access(1'b0, 1'b0, 1'b0, 1'b0, 17'h0_0005, 16'h0000);
    check("status after reset", got, 16'h0000);
  endtask
  task automatic sc_supply();
    @(posedge clk);
    req_high_supply <= 1'b1;
    repeat (100) access(1'b1, 1'b0, 1'b0, 1'b1, 17'h0_0008, 16'h00ff);
    @(negedge clk);
    check("high supply used", {15'h0000, program_supply_high}, 16'h0001);
    access(1'b1, 1'b0, 1'b0, 1'b1, 17'h0_0008, 16'h00ff);
    @(negedge clk);
    check("high supply spent", {15'h0000, program_supply_high}, 16'h0000);
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    check("idle strobes", {13'h0000, chip_select_n, output_enable_n, write_strobe_n},
      16'h0007);
    check("idle level", {14'h0000, reset_powerdown_level}, {14'h0000, RP_HIGH});
    sc_word();
    sc_byte();
    sc_boot();
    sc_reset();
    sc_supply();
    final_report();
  end
endmodule
